//--- hw/pmirq_pkg.sv
// Purpose: constants and types for the interrupt mask and request-pin block
// Assumes: APB register access, one word per register index
// Notes:   byte address of a register is four times its index
package pmirq_pkg;

    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int IDX_W  = 15;
    localparam int GPIO_N = 3;

    ////////////////////////////////////////////////////////////////////////
    // register indices
    localparam logic [IDX_W-1:0] IDX_GPIO_EVENT  = 15'h4015;
    localparam logic [IDX_W-1:0] IDX_PIN_CONFIG  = 15'h4017;
    localparam logic [IDX_W-1:0] IDX_CAT_MASK    = 15'h4018;
    localparam logic [IDX_W-1:0] IDX_S1_MASK     = 15'h4019;
    localparam logic [IDX_W-1:0] IDX_GPIO_MASK   = 15'h4020;
    localparam logic [IDX_W-1:0] IDX_GPIO_TRIG   = 15'h4021;

    ////////////////////////////////////////////////////////////////////////
    // category bit positions
    localparam int CAT_POWER_STATE  = 15;
    localparam int CAT_TEMPERATURE  = 14;
    localparam int CAT_GPIO         = 13;
    localparam int CAT_ONPIN        = 12;
    localparam int CAT_WATCHDOG     = 11;
    localparam int CAT_AUX_CONV     = 8;
    localparam int CAT_POWER_PATH   = 7;
    localparam int CAT_CURRENT_SINK = 6;
    localparam int CAT_CLOCK        = 5;
    localparam int CAT_ONETIME_MEM  = 4;
    localparam int CAT_CHARGER      = 2;
    localparam int CAT_HIGH_CURRENT = 1;
    localparam int CAT_UNDERVOLTAGE = 0;
    localparam logic [REG_W-1:0] CAT_IMPL = 16'hf9f7;

    // status-one mask: bits 15..11 held here
    localparam int S1_LSB = 11;
    localparam int S1_N   = 5;
    localparam int S1_SYSTEM_LOW   = 4;
    localparam int S1_POWER_SOURCE = 3;
    localparam int S1_USB_CURRENT  = 2;
    localparam int S1_ONPIN_CHANGE = 1;
    localparam int S1_WDOG_TIMEOUT = 0;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [GPIO_N-1:0]   GPIO_EVENT_RST = 3'h0;
    localparam logic [1:0]          PIN_CONFIG_RST = 2'h2;
    localparam logic [REG_W-1:0]    CAT_MASK_RST   = 16'hf9f7;
    localparam logic [S1_N-1:0]     S1_MASK_RST    = 5'h1f;
    localparam logic [GPIO_N-1:0]   GPIO_MASK_RST  = 3'h7;
    localparam logic [2*GPIO_N-1:0] GPIO_TRIG_RST  = 6'h00;

    typedef enum logic [1:0] {
        PMIRQ_TRIG_RISE,
        PMIRQ_TRIG_FALL,
        PMIRQ_TRIG_BOTH,
        PMIRQ_TRIG_HIGH
    } pmirq_trig_t;

    typedef struct packed {
        logic drive_type;
        logic output_block;
    } pmirq_pin_cfg_t;

endpackage

//--- hw/pmirq_top.sv
// Purpose: gpio event latches, category masks and interrupt request pin
// Assumes: inputs synchronous to REF_CLK; APB3 slave with no wait states
// Notes:   request pin is active low; pin follows INT_REQ in the same cycle while output block is 0
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

// Functional notes
// R1 - gpio lines 3,2,1 latch at status bits 2,1,0 per own trigger mode
// R2 - latches reset to 0, stay set until software writes one to them
// R3 - drive type 0 push-pull, 1 open-drain with pull-up; resets to 1
// R4 - output block resets 0; when 1 the request pin never signals
// R5 - mask bit 0 lets event contribute; 1 suppresses it
// R6 - every first and second level mask bit resets to 1
// R7 - category mask bits: 15,14,13,12,11,8,7,6,5,4,2,1,0 by category
// R8 - assert pin while unmasked category pending and not blocked
module pmirq_top (
    input  wire logic                          REF_CLK,
    input  wire logic                          RST_N,
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [pmirq_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [pmirq_pkg::DATA_W-1:0]  PWDATA,
    output logic      [pmirq_pkg::DATA_W-1:0]  PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    input  wire logic [pmirq_pkg::GPIO_N-1:0]  GPIO_IN,
    input  wire logic [pmirq_pkg::REG_W-1:0]   CAT_PENDING,
    input  wire logic [pmirq_pkg::S1_N-1:0]    S1_LATCH,
    output logic                               INT_REQ,
    output logic                               REQ_PIN_O,
    output logic                               REQ_PIN_OE
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic reg_hit(
        input logic [pmirq_pkg::ADDR_W-1:0] addr,
        input logic [pmirq_pkg::IDX_W-1:0]  idx
    );
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    function automatic logic trig_hit(
        input logic [1:0] mode,
        input logic       cur,
        input logic       prev
    );
        case (pmirq_pkg::pmirq_trig_t'(mode))
            pmirq_pkg::PMIRQ_TRIG_RISE: trig_hit = cur & ~prev;
            pmirq_pkg::PMIRQ_TRIG_FALL: trig_hit = ~cur & prev;
            pmirq_pkg::PMIRQ_TRIG_BOTH: trig_hit = cur ^ prev;
            pmirq_pkg::PMIRQ_TRIG_HIGH: trig_hit = cur;
            default:                    trig_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [pmirq_pkg::GPIO_N-1:0]   gpio_event;
    logic [pmirq_pkg::GPIO_N-1:0]   gpio_prev;
    pmirq_pkg::pmirq_pin_cfg_t      pin_cfg;
    logic [pmirq_pkg::REG_W-1:0]    cat_mask;
    logic [pmirq_pkg::S1_N-1:0]     s1_mask;
    logic [pmirq_pkg::GPIO_N-1:0]   gpio_mask;
    logic [2*pmirq_pkg::GPIO_N-1:0] gpio_trig;
    logic                           req;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire setup_phase  = PSEL & ~PENABLE;
    wire access_phase = PSEL & PENABLE;
    wire wr_access    = access_phase & PWRITE;

    wire hit_event  = reg_hit(PADDR, pmirq_pkg::IDX_GPIO_EVENT);
    wire hit_pin    = reg_hit(PADDR, pmirq_pkg::IDX_PIN_CONFIG);
    wire hit_cat    = reg_hit(PADDR, pmirq_pkg::IDX_CAT_MASK);
    wire hit_s1     = reg_hit(PADDR, pmirq_pkg::IDX_S1_MASK);
    wire hit_gmask  = reg_hit(PADDR, pmirq_pkg::IDX_GPIO_MASK);
    wire hit_gtrig  = reg_hit(PADDR, pmirq_pkg::IDX_GPIO_TRIG);
    wire hit_any    = hit_event | hit_pin | hit_cat | hit_s1 |
                      hit_gmask | hit_gtrig;

    wire wr_event   = wr_access & hit_event;
    wire wr_pin     = wr_access & hit_pin;
    wire wr_cat     = wr_access & hit_cat;
    wire wr_s1      = wr_access & hit_s1;
    wire wr_gmask   = wr_access & hit_gmask;
    wire wr_gtrig   = wr_access & hit_gtrig;

    // zero wait states: every access phase completes at once
    assign PREADY  = 1'b1;
    assign PSLVERR = access_phase & ~hit_any;

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle so it is a flop output

    logic [pmirq_pkg::REG_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (hit_event)
            rd_mux[pmirq_pkg::GPIO_N-1:0] = gpio_event;
        if (hit_pin)
            rd_mux[1:0] = pin_cfg;
        if (hit_cat)
            rd_mux = cat_mask & pmirq_pkg::CAT_IMPL;
        if (hit_s1)
            rd_mux[pmirq_pkg::REG_W-1:pmirq_pkg::S1_LSB] = s1_mask;
        if (hit_gmask)
            rd_mux[pmirq_pkg::GPIO_N-1:0] = gpio_mask;
        if (hit_gtrig)
            rd_mux[2*pmirq_pkg::GPIO_N-1:0] = gpio_trig;
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
            PRDATA <= '0;
        else if (setup_phase && !PWRITE)
            PRDATA <= {{(pmirq_pkg::DATA_W-pmirq_pkg::REG_W){1'b0}}, rd_mux};
    end

    ////////////////////////////////////////////////////////////////////////
    // gpio event latches

    logic [pmirq_pkg::GPIO_N-1:0] gpio_set;
    logic [pmirq_pkg::GPIO_N-1:0] gpio_clr;
    logic [pmirq_pkg::GPIO_N-1:0] next_gpio_event;

    genvar g;
    generate
        for (g = 0; g < pmirq_pkg::GPIO_N; g++) begin : g_line
            assign gpio_set[g] = trig_hit(gpio_trig[2*g +: 2],
                                          GPIO_IN[g], gpio_prev[g]); // R1
        end
    endgenerate

    // write-one-to-clear; a new event in the same cycle wins
    assign gpio_clr        = wr_event ? PWDATA[pmirq_pkg::GPIO_N-1:0] : '0;
    assign next_gpio_event = (gpio_event & ~gpio_clr) | gpio_set; // R2

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gpio_event <= pmirq_pkg::GPIO_EVENT_RST; // R2
            gpio_prev  <= '0;
        end else begin
            gpio_event <= next_gpio_event;
            gpio_prev  <= GPIO_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration and mask registers

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_cfg   <= pmirq_pkg::PIN_CONFIG_RST; // R3 R4
            cat_mask  <= pmirq_pkg::CAT_MASK_RST; // R6
            s1_mask   <= pmirq_pkg::S1_MASK_RST; // R6
            gpio_mask <= pmirq_pkg::GPIO_MASK_RST;
            gpio_trig <= pmirq_pkg::GPIO_TRIG_RST;
        end else begin
            if (wr_pin)
                pin_cfg <= PWDATA[1:0];
            if (wr_cat)
                cat_mask <= PWDATA[pmirq_pkg::REG_W-1:0]
                            & pmirq_pkg::CAT_IMPL; // R7
            if (wr_s1)
                s1_mask <= PWDATA[pmirq_pkg::REG_W-1:pmirq_pkg::S1_LSB];
            if (wr_gmask)
                gpio_mask <= PWDATA[pmirq_pkg::GPIO_N-1:0];
            if (wr_gtrig)
                gpio_trig <= PWDATA[2*pmirq_pkg::GPIO_N-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // category summary and request

    logic [pmirq_pkg::S1_N-1:0]  s1_live;
    logic [pmirq_pkg::REG_W-1:0] cat_src;
    logic [pmirq_pkg::REG_W-1:0] cat_live;
    wire                         gpio_live = |(gpio_event & ~gpio_mask);

    assign s1_live = S1_LATCH & ~s1_mask; // R5

    // local sources join the summaries made elsewhere in the controller
    always_comb begin
        cat_src = CAT_PENDING & pmirq_pkg::CAT_IMPL;
        cat_src[pmirq_pkg::CAT_GPIO] = cat_src[pmirq_pkg::CAT_GPIO]
                                       | gpio_live; // R7
        cat_src[pmirq_pkg::CAT_POWER_PATH] =
            cat_src[pmirq_pkg::CAT_POWER_PATH]
            | s1_live[pmirq_pkg::S1_SYSTEM_LOW]
            | s1_live[pmirq_pkg::S1_POWER_SOURCE]
            | s1_live[pmirq_pkg::S1_USB_CURRENT];
        cat_src[pmirq_pkg::CAT_ONPIN] = cat_src[pmirq_pkg::CAT_ONPIN]
                                        | s1_live[pmirq_pkg::S1_ONPIN_CHANGE];
        cat_src[pmirq_pkg::CAT_WATCHDOG] =
            cat_src[pmirq_pkg::CAT_WATCHDOG]
            | s1_live[pmirq_pkg::S1_WDOG_TIMEOUT];
    end

    assign cat_live = cat_src & ~cat_mask; // R5 R7
    wire   next_req = |cat_live;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
            req <= 1'b0;
        else
            req <= next_req; // R8
    end

    assign INT_REQ = req;

    ////////////////////////////////////////////////////////////////////////
    // request pin, active low

    // blocking gates only the pin; INT_REQ still shows pending work
    wire pin_assert = req & ~pin_cfg.output_block; // R4 R8

    // open drain: release high via pull-up, never drive high
    assign REQ_PIN_O  = pin_cfg.drive_type ? 1'b0 : ~pin_assert; // R3
    assign REQ_PIN_OE = pin_cfg.drive_type ? pin_assert : 1'b1; // R3

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic seen_clk;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
            seen_clk <= 1'b0;
        else
            seen_clk <= 1'b1;
    end

    sequence s_rise_line0;
        (gpio_trig[1:0] == 2'h0) && !gpio_prev[0] && GPIO_IN[0];
    endsequence

    sequence s_clear_line0;
        wr_event && PWDATA[0] && !gpio_set[0];
    endsequence

    property p_gpio_rise_latch;
        @(posedge REF_CLK) disable iff (!RST_N)
        s_rise_line0 |=> gpio_event[0];
    endproperty
    a_gpio_rise_latch: assert property (p_gpio_rise_latch) // R1
        else $error("rising edge on gpio line not latched");

    property p_w1c_clear;
        @(posedge REF_CLK) disable iff (!RST_N)
        s_clear_line0 |=> !gpio_event[0];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) // R2
        else $error("write of one did not clear the latch");

    property p_set_wins;
        @(posedge REF_CLK) disable iff (!RST_N)
        (wr_event && PWDATA[1] && gpio_set[1]) |=> gpio_event[1];
    endproperty
    a_set_wins: assert property (p_set_wins) // R2
        else $error("event lost during clear");

    property p_latch_holds;
        @(posedge REF_CLK) disable iff (!RST_N)
        (gpio_event[2] && !(wr_event && PWDATA[2])) |=> gpio_event[2];
    endproperty
    a_latch_holds: assert property (p_latch_holds) // R2
        else $error("latch dropped without a clear");

    property p_drive_cmos;
        @(posedge REF_CLK) disable iff (!RST_N)
        !pin_cfg.drive_type |-> REQ_PIN_OE && (REQ_PIN_O == !pin_assert);
    endproperty
    a_drive_cmos: assert property (p_drive_cmos) // R3
        else $error("push-pull pin drive wrong");

    property p_drive_od;
        @(posedge REF_CLK) disable iff (!RST_N)
        pin_cfg.drive_type |-> !REQ_PIN_O && (REQ_PIN_OE == pin_assert);
    endproperty
    a_drive_od: assert property (p_drive_od) // R3
        else $error("open-drain pin drive wrong");

    property p_pin_blocked;
        @(posedge REF_CLK) disable iff (!RST_N)
        pin_cfg.output_block |-> (REQ_PIN_OE ? REQ_PIN_O : 1'b1);
    endproperty
    a_pin_blocked: assert property (p_pin_blocked) // R4
        else $error("blocked pin still signals");

    property p_reset_values;
        @(posedge REF_CLK) disable iff (!RST_N)
        !seen_clk |-> (cat_mask == 16'hf9f7) && (s1_mask == 5'h1f)
                      && (pin_cfg == 2'h2) && (gpio_event == 3'h0);
    endproperty
    a_reset_values: assert property (p_reset_values) // R6
        else $error("wrong value after reset");

    property p_masked_cat;
        @(posedge REF_CLK) disable iff (!RST_N)
        (cat_mask[pmirq_pkg::CAT_GPIO] && cat_src == 16'h2000) |=> !req;
    endproperty
    a_masked_cat: assert property (p_masked_cat) // R5
        else $error("masked gpio category raised request");

    property p_gpio_cat_bit;
        @(posedge REF_CLK) disable iff (!RST_N)
        (gpio_live && !cat_mask[13]) |=> req;
    endproperty
    a_gpio_cat_bit: assert property (p_gpio_cat_bit) // R7
        else $error("gpio category not at bit 13");

    property p_req_follows;
        @(posedge REF_CLK) disable iff (!RST_N)
        ##1 req == $past(next_req);
    endproperty
    a_req_follows: assert property (p_req_follows) // R8
        else $error("request does not track pending categories");

    property p_fall_latch;
        @(posedge REF_CLK) disable iff (!RST_N)
        (gpio_trig[3:2] == 2'h1 && gpio_prev[1] && !GPIO_IN[1])
            |=> gpio_event[1];
    endproperty
    a_fall_latch: assert property (p_fall_latch) // R1
        else $error("falling edge on gpio line not latched");

    property p_level_latch;
        @(posedge REF_CLK) disable iff (!RST_N)
        (gpio_trig[5:4] == 2'h3 && GPIO_IN[2]) |=> gpio_event[2];
    endproperty
    a_level_latch: assert property (p_level_latch) // R1
        else $error("high level on gpio line not latched");

    property p_req_release;
        @(posedge REF_CLK) disable iff (!RST_N)
        (cat_live == '0) |=> !req;
    endproperty
    a_req_release: assert property (p_req_release) // R8
        else $error("request held with nothing pending");

    // a released pin must read idle in either drive type
    property p_pin_idle;
        @(posedge REF_CLK) disable iff (!RST_N)
        !req |-> (REQ_PIN_O || !REQ_PIN_OE);
    endproperty
    a_pin_idle: assert property (p_pin_idle) // R8
        else $error("request pin signals with no request");

endmodule

//--- tb/pmic_irq_mask_and_output_test.sv
// Purpose: self-checking bench for the mask and request pin block
// Assumes: apb slave answers in the access phase
// Notes:   reference model runs beside the design every cycle
`timescale 1ns/1ps
module pmic_irq_mask_and_output_test;
    logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        INT_REQ, REQ_PIN_O, REQ_PIN_OE, pin_level, rnd_on;
    logic [16:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, m_rd, r;
    logic [2:0]  GPIO_IN, m_ev, m_gm, m_prev, hit;
    logic [15:0] CAT_PENDING, m_cm, pend;
    logic [4:0]  S1_LATCH, m_s1;
    logic [5:0]  m_tr;
    logic [1:0]  m_cfg;
    logic        m_int, wr, exp_last;
    logic [14:0] ix;
    int          seed, error_cnt, num_checks, cyc, req_seen, exp_seen;
    pmirq_top dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .GPIO_IN(GPIO_IN), .CAT_PENDING(CAT_PENDING),
        .S1_LATCH(S1_LATCH), .INT_REQ(INT_REQ), .REQ_PIN_O(REQ_PIN_O),
        .REQ_PIN_OE(REQ_PIN_OE));
    pmirq_host host_u (.clk(REF_CLK), .pin_o(REQ_PIN_O), .pin_oe(REQ_PIN_OE),
        .pin_level(pin_level), .req_seen(req_seen));
    always #4 REF_CLK = ~REF_CLK;
    ////////////////////////////////////////////////////////////////////////
    // reference model
    assign wr = PSEL & PENABLE & PWRITE;
    assign ix = PADDR[16:2];
    function automatic logic mapped(input logic [14:0] a);
        return a inside {pmirq_pkg::IDX_GPIO_EVENT, pmirq_pkg::IDX_PIN_CONFIG,
            pmirq_pkg::IDX_CAT_MASK, pmirq_pkg::IDX_S1_MASK,
            pmirq_pkg::IDX_GPIO_MASK, pmirq_pkg::IDX_GPIO_TRIG};
    endfunction
    function automatic logic [31:0] rdval(input logic [14:0] a);
        case (a)
            pmirq_pkg::IDX_GPIO_EVENT: return {29'h0, m_ev};
            pmirq_pkg::IDX_PIN_CONFIG: return {30'h0, m_cfg};
            pmirq_pkg::IDX_CAT_MASK:   return {16'h0, m_cm};
            pmirq_pkg::IDX_S1_MASK:    return {16'h0, m_s1, 11'h0};
            pmirq_pkg::IDX_GPIO_MASK:  return {29'h0, m_gm};
            pmirq_pkg::IDX_GPIO_TRIG:  return {26'h0, m_tr};
            default:                   return 32'h0;
        endcase
    endfunction
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            case (m_tr[2*i+:2])
                2'h0:    hit[i] = GPIO_IN[i] & ~m_prev[i];
                2'h1:    hit[i] = ~GPIO_IN[i] & m_prev[i];
                2'h2:    hit[i] = GPIO_IN[i] ^ m_prev[i];
                default: hit[i] = GPIO_IN[i];
            endcase
        end
        pend = CAT_PENDING & pmirq_pkg::CAT_IMPL;
        pend[7] = pend[7] | (|(S1_LATCH[4:2] & ~m_s1[4:2]));
        pend[12] = pend[12] | (S1_LATCH[1] & ~m_s1[1]);
        pend[11] = pend[11] | (S1_LATCH[0] & ~m_s1[0]);
        pend[13] = pend[13] | (|(m_ev & ~m_gm));
    end
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {m_ev, m_prev, m_tr, m_int, m_rd} <= '0;
            {m_cfg, m_cm, m_s1, m_gm} <= {2'h2, 16'hf9f7, 5'h1f, 3'h7};
        end else begin
            m_prev <= GPIO_IN;
            m_int <= |(pend & ~m_cm);
            m_ev <= (m_ev & ~((wr && ix == pmirq_pkg::IDX_GPIO_EVENT) ?
                PWDATA[2:0] : 3'h0)) | hit;
            if (PSEL && !PENABLE) m_rd <= rdval(ix);
            if (wr) begin
                case (ix)
                    pmirq_pkg::IDX_PIN_CONFIG: m_cfg <= PWDATA[1:0];
                    pmirq_pkg::IDX_CAT_MASK:
                        m_cm <= PWDATA[15:0] & pmirq_pkg::CAT_IMPL;
                    pmirq_pkg::IDX_S1_MASK:    m_s1 <= PWDATA[15:11];
                    pmirq_pkg::IDX_GPIO_MASK:  m_gm <= PWDATA[2:0];
                    pmirq_pkg::IDX_GPIO_TRIG:  m_tr <= PWDATA[5:0];
                    default: ;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [14:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        {PSEL, PENABLE, PWRITE} <= {1'b1, 1'b0, w};
        PADDR <= {a, 2'h0};
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1 && n < 50) begin
            n++;
            @(posedge REF_CLK);
        end
        if (n == 50) error_cnt++;
        rd = PRDATA;
        check({31'h0, PSLVERR}, {31'h0, !mapped(a)});
        if (!w) check(rd, m_rd);
        {PSEL, PENABLE} <= 2'h0;
    endtask
    task automatic chk_rst();
        apb(1'b0, pmirq_pkg::IDX_GPIO_EVENT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, pmirq_pkg::IDX_PIN_CONFIG, 32'h0);
        check(rd, 32'h2);
        apb(1'b0, pmirq_pkg::IDX_CAT_MASK, 32'h0);
        check(rd, 32'hf9f7);
        apb(1'b0, pmirq_pkg::IDX_S1_MASK, 32'h0);
        check(rd, 32'hf800);
        apb(1'b0, 15'h4016, 32'h0);
        check(rd, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge REF_CLK) begin
        if (RST_N) begin
            check({31'h0, INT_REQ}, {31'h0, m_int});
            check({31'h0, pin_level}, {31'h0, ~(m_int & ~m_cfg[0])});
            check({31'h0, REQ_PIN_OE},
                {31'h0, m_cfg[1] ? (m_int & ~m_cfg[0]) : 1'b1});
        end
        // expected count of pin assertions, sampled as the host does
        if (exp_last && m_int && !m_cfg[0])
            exp_seen++;
        exp_last = !(m_int && !m_cfg[0]);
    end
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // only driver of the side inputs after time zero, so no two writes share an edge
    always @(posedge REF_CLK) begin
        if (rnd_on) begin
            r = $random(seed);
            GPIO_IN <= r[2:0];
            CAT_PENDING <= r[18:3] & r[31:16];
            S1_LATCH <= r[23:19];
        end else begin
            {GPIO_IN, CAT_PENDING, S1_LATCH} <= '0;
        end
    end
    initial begin
        {REF_CLK, RST_N, PSEL, PENABLE, PWRITE, rnd_on} = '0;
        {PADDR, PWDATA, GPIO_IN, CAT_PENDING, S1_LATCH} = '0;
        seed = 96;
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        exp_seen = 0;
        exp_last = 1'b1;
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        chk_rst();
        apb(1'b1, pmirq_pkg::IDX_CAT_MASK, 32'hffffffff);
        apb(1'b0, pmirq_pkg::IDX_CAT_MASK, 32'h0);
        apb(1'b1, pmirq_pkg::IDX_GPIO_MASK, 32'h0);
        apb(1'b1, pmirq_pkg::IDX_S1_MASK, 32'h0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, pmirq_pkg::IDX_PIN_CONFIG, 32'(m));
            apb(1'b1, pmirq_pkg::IDX_GPIO_TRIG, 32'(m * 21));
            apb(1'b1, pmirq_pkg::IDX_CAT_MASK,
                m[0] ? $random(seed) : 32'hdfff);
            rnd_on <= 1'b1;
            repeat (30) @(posedge REF_CLK);
            apb(1'b1, pmirq_pkg::IDX_GPIO_EVENT, 32'h7);
            rnd_on <= 1'b0;
            repeat (3) @(posedge REF_CLK);
            apb(1'b1, pmirq_pkg::IDX_GPIO_EVENT, 32'h7);
            apb(1'b0, pmirq_pkg::IDX_GPIO_EVENT, 32'h0);
            apb(1'b1, pmirq_pkg::IDX_S1_MASK, $random(seed));
            apb(1'b1, 15'h4016, 32'hffff);
        end
        // mid-run reset with masks rewritten must restore the event, pin, category and status-one mask defaults
        RST_N <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        RST_N <= 1'b1;
        chk_rst();
        check(req_seen, exp_seen);
        close_out();
    end
endmodule

//--- tb/pmirq_host.sv
// Purpose: host side of the interrupt request pin
// Assumes: pin has a pull-up to the high level
// Notes:   undriven pin reads as the pull-up level, never a stale value
`timescale 1ns/1ps
module pmirq_host (
    input  wire logic clk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_level,
    output int        req_seen
);
    logic last_level;
    // released pin floats up, so an open-drain release reads high
    assign pin_level = pin_oe ? pin_o : 1'b1;
    initial begin
        req_seen = 0;
        last_level = 1'b1;
    end
    // host counts request assertions (active low pin); sampled mid-cycle
    // so that same-edge changes of drive type cannot count as a glitch
    always @(negedge clk) begin
        if (last_level && !pin_level)
            req_seen++;
        last_level = pin_level;
    end
endmodule
